// file: logic/pie_pkg.sv
/*
 holds the constants and carrier types of the peripheral interrupt
 enable bank two block.
 assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package pie_pkg;
   // byte addresses of the registers
   localparam logic [3:0] PIE_ADDR_ENABLE = 4'h0;  // enable bank two
   localparam logic [3:0] PIE_ADDR_STATUS = 4'h4;  // pending and requests
   localparam logic [3:0] PIE_ADDR_CTRL = 4'h8;    // global enable copy
   // bit positions inside the enable bank
   localparam int PIE_BIT_ZCD = 6;   // zero-cross enable
   localparam int PIE_BIT_CMPB = 1;  // second comparator enable
   localparam int PIE_BIT_CMPA = 0;  // first comparator enable
   localparam int PIE_BIT_GLOBAL = 0; // global enable in control reg
   // implemented-bit mask and reset value
   localparam logic [7:0] PIE_IMPL_MASK = 8'h43;
   localparam logic [7:0] PIE_RESET_VAL = 8'h00;
   localparam logic [23:0] PIE_ZERO_PAD = 24'h00_0000;
   localparam logic [6:0] PIE_ZERO_CTRL = 7'h00;
   localparam logic [1:0] PIE_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIE_RESP_SLVERR = 2'h2;

   // source pending flags toward the gate
   typedef struct packed {
      logic zero_cross;
      logic comparator_b;
      logic comparator_a;
   } pie_src_t;
endpackage

// file: logic/pie_bank.sv
/*
 holds the enable bank two register with its AXI4-Lite slave and the
 gating of three peripheral interrupt requests.
 assumes the pending flags arrive on I_CLK from same-clock logic and
 that the global interrupt enable is applied beyond this block.
*/
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - bit 6 gates zero-cross request
// - bits 1 and 0 gate comparators
// - unimplemented bits ignore writes, read zero
// - implemented bits read/write, reset to zero
// - O_PERIPH_IRQ needs peripheral global enable set; O_REQUEST does not
module pie_bank (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic [3:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [3:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   input wire pie_pkg::pie_src_t I_PENDING,
   output pie_pkg::pie_src_t O_REQUEST,
   output logic O_PERIPH_IRQ
);
   import pie_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] enable_reg;     // enable bank two, implemented bits only
   logic global_en;            // peripheral global enable copy
   logic aw_held;              // write address captured
   logic w_held;               // write data captured
   logic [3:0] aw_addr;        // captured write address
   logic [31:0] w_data;        // captured write data
   logic [3:0] w_strb;         // captured byte strobes
   logic bvalid;               // write response pending
   logic [1:0] bresp;          // write response code
   logic rvalid;               // read response pending
   logic [31:0] rdata;         // read data register
   logic [1:0] rresp;          // read response code

   // address is one of the three registers
   function automatic logic pie_mapped(input logic [3:0] a);
      pie_mapped = (a == PIE_ADDR_ENABLE) || (a == PIE_ADDR_STATUS) ||
                   (a == PIE_ADDR_CTRL);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // handshake decode
   // each channel accepts once per write; no new write until b retires
   // readys are combinational from the held flags; a master that waits
   // for ready before raising valid still works, as the flags reset low
   wire aw_take = I_AWVALID && O_AWREADY;
   wire w_take = I_WVALID && O_WREADY;
   wire do_write = aw_held && w_held && !bvalid;
   wire ar_take = I_ARVALID && O_ARREADY;
   wire wr_enable = do_write && (aw_addr == PIE_ADDR_ENABLE) && w_strb[0];
   wire wr_ctrl = do_write && (aw_addr == PIE_ADDR_CTRL) && w_strb[0];
   // unimplemented bits are masked off so writes cannot reach them
   wire [7:0] next_enable = w_data[7:0] & PIE_IMPL_MASK;

   assign O_AWREADY = !aw_held && !bvalid;
   assign O_WREADY = !w_held && !bvalid;
   assign O_ARREADY = !rvalid;
   assign O_BVALID = bvalid;
   assign O_BRESP = bresp;
   assign O_RVALID = rvalid;
   assign O_RDATA = rdata;
   assign O_RRESP = rresp;

   ////////////////////////////////////////////////////////////////////
   // request gating
   // pending flags are taken as same-clock levels; a flag from another
   // clock would need a synchroniser ahead of this block
   wire req_zcd = I_PENDING.zero_cross && enable_reg[PIE_BIT_ZCD];
   wire req_b = I_PENDING.comparator_b && enable_reg[PIE_BIT_CMPB];
   wire req_a = I_PENDING.comparator_a && enable_reg[PIE_BIT_CMPA];
   // per-source AND before any peripheral or global gating
   wire pie_src_t next_req = '{req_zcd, req_b, req_a};
   // peripheral line held off while the global enable is clear
   wire next_irq = global_en && (req_zcd || req_b || req_a);

   ////////////////////////////////////////////////////////////////////
   // read mux; status shows pending flags low and requests above
   // data is captured at the address handshake, so a flag that moves
   // while the answer waits cannot tear the returned word
   wire [7:0] status_val = {2'b00, O_REQUEST, I_PENDING};
   wire [31:0] next_rdata =
      (I_ARADDR == PIE_ADDR_ENABLE) ? {PIE_ZERO_PAD, enable_reg} :
      (I_ARADDR == PIE_ADDR_STATUS) ? {PIE_ZERO_PAD, status_val} :
      (I_ARADDR == PIE_ADDR_CTRL) ?
         {PIE_ZERO_PAD, PIE_ZERO_CTRL, global_en} : 32'h0000_0000;
   wire [1:0] next_rresp = pie_mapped(I_ARADDR) ? PIE_RESP_OKAY :
                           PIE_RESP_SLVERR;
   wire [1:0] next_bresp = pie_mapped(aw_addr) ? PIE_RESP_OKAY :
                           PIE_RESP_SLVERR;

   ////////////////////////////////////////////////////////////////////
   // enable bank; every reset clears it
   // a write with the low strobe clear leaves the bank as it was
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         enable_reg <= PIE_RESET_VAL;
      end else if (wr_enable) begin
         enable_reg <= next_enable;
      end
   end

   // global enable copy
   // stands in for the bit of the interrupt control register; the
   // real gate toward vectoring still sits beyond this block
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         global_en <= 1'b0;
      end else if (wr_ctrl) begin
         global_en <= w_data[PIE_BIT_GLOBAL];
      end
   end

   // registered request outputs, one cycle behind the flags
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_REQUEST <= '0;
         O_PERIPH_IRQ <= 1'b0;
      end else begin
         O_REQUEST <= next_req;
         O_PERIPH_IRQ <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write address and data capture, either order
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= I_AWADDR;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_data <= I_WDATA;
         w_strb <= I_WSTRB;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // write response
   // the answer waits for bready; a master that never raises it
   // stalls all further writes, which is the intended back-pressure
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         bvalid <= 1'b0;
         bresp <= PIE_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= next_bresp;
      end else if (I_BREADY) begin
         bvalid <= 1'b0;
      end
   end

   // read response, data sampled at the address handshake
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= PIE_RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end else if (I_RREADY) begin
         rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks on the request gates; each gate is watched in both
   // directions so a gate stuck open or stuck shut both show up
   a_zcd_gate: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_REQUEST.zero_cross == ($past(I_PENDING.zero_cross) &&
      $past(enable_reg[PIE_BIT_ZCD])))
      else $error("zero-cross request gating wrong");
   a_zcd_block: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      !$past(enable_reg[PIE_BIT_ZCD]) |-> !O_REQUEST.zero_cross)
      else $error("zero-cross request while disabled");
   a_cmpb_gate: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      !$past(enable_reg[PIE_BIT_CMPB]) |-> !O_REQUEST.comparator_b)
      else $error("comparator b request while disabled");
   a_cmpb_pass: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      $past(I_PENDING.comparator_b && enable_reg[PIE_BIT_CMPB])
      |-> O_REQUEST.comparator_b)
      else $error("comparator b request lost");
   a_cmpa_gate: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      $past(I_PENDING.comparator_a && enable_reg[PIE_BIT_CMPA])
      |-> O_REQUEST.comparator_a)
      else $error("comparator a request lost");
   a_cmpa_block: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      !$past(enable_reg[PIE_BIT_CMPA]) |-> !O_REQUEST.comparator_a)
      else $error("comparator a request while disabled");
   // no request may stand without its pending flag behind it
   a_req_pending: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      (O_REQUEST & ~$past(I_PENDING)) == '0)
      else $error("request without pending flag");

   ////////////////////////////////////////////////////////////////////
   // checks on the enable bank itself
   a_unimpl_zero: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      (enable_reg & ~PIE_IMPL_MASK) == PIE_RESET_VAL)
      else $error("unimplemented enable bit set");
   // only the low byte carries a register; the rest reads zero
   a_upper_zero: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_RVALID |-> O_RDATA[31:8] == PIE_ZERO_PAD)
      else $error("read data above the byte not zero");
   a_enable_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      wr_enable |=> enable_reg == ($past(w_data[7:0]) & PIE_IMPL_MASK))
      else $error("enable write not stored");
   a_enable_hold: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      !wr_enable |=> $stable(enable_reg))
      else $error("enable changed without write");

   ////////////////////////////////////////////////////////////////////
   // checks on the peripheral line and its global enable
   a_global_gate: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_PERIPH_IRQ |-> $past(global_en))
      else $error("irq while global enable clear");
   a_global_write: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      wr_ctrl |=> global_en == $past(w_data[PIE_BIT_GLOBAL]))
      else $error("global enable write not stored");
   a_irq_source: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      $past(global_en) && $past(next_req != '0) |-> O_PERIPH_IRQ)
      else $error("gated request did not raise irq");

   ////////////////////////////////////////////////////////////////////
   // checks on the register bus handshakes
   a_read_answer: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      ar_take |=> O_RVALID)
      else $error("read not answered next cycle");
   a_write_answer: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      do_write |=> O_BVALID)
      else $error("write not answered next cycle");
   // an answer must stand, unchanged, until the master takes it
   a_bresp_hold: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   a_rdata_hold: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped early");
   // no new address or data is taken while an answer is waiting
   a_write_refuse: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_BVALID |-> !O_AWREADY && !O_WREADY)
      else $error("write taken while response pending");
   a_read_refuse: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      O_RVALID |-> !O_ARREADY)
      else $error("read taken while data pending");
   // unmapped offsets must answer with the error code
   a_write_code: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      do_write && !pie_mapped(aw_addr) |=> O_BRESP == PIE_RESP_SLVERR)
      else $error("unmapped write answered okay");
   a_read_code: assert property (
      @(posedge I_CLK) disable iff (!I_RST_B)
      ar_take && !pie_mapped(I_ARADDR) |=> O_RRESP == PIE_RESP_SLVERR)
      else $error("unmapped read answered okay");
endmodule

// file: tb/pie_bank_test.sv
/*
 self-checking bench for the enable bank two block.
 assumes the AXI4-Lite slave and gating of logic/pie_bank.sv.
*/
`timescale 1ns/10ps
module pie_bank_test;
   import pie_pkg::*;
   logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready; // drives
   logic [3:0] awaddr, araddr, wstrb; // address and strobes
   logic [3:0] strb = 4'hf; // byte strobes used by the next write
   logic [31:0] wdata, rd_d; // write data, read result
   logic [1:0] rsp; // response seen
   pie_src_t pend; // pending flags toward the gate
   logic [1:0] bresp, rresp; // slave responses
   logic awready, wready, bvalid, arready, rvalid, irq; // slave outputs
   logic [31:0] rdata; // read data
   pie_src_t req; // gated requests
   int failures = 0, n_compared = 0, cyc = 0; // counters
   pie_bank DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
      .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready), .I_PENDING(pend), .O_REQUEST(req),
      .O_PERIPH_IRQ(irq));
   ////////////////////////////////////////////////////////////////////
   // clock and hang guard; the ceiling is far above the real run
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
         input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // bus master: each channel released at the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; wstrb <= strb;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      rd_d = rdata;
      rsp = rresp;
      rready <= 0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   // reset values, then a second reset after the bits were set
   task automatic t_reset();
      rd(PIE_ADDR_ENABLE);
      chk("enable after reset", rd_d, 32'h0000_0000);
      wr(PIE_ADDR_ENABLE, 32'h0000_0043);
      rd(PIE_ADDR_ENABLE);
      chk("enable before second reset", rd_d, 32'h0000_0043);
      rst_b <= 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      rd(PIE_ADDR_ENABLE);
      chk("enable after second reset", rd_d, 32'h0000_0000);
      $display("test reset done");
   endtask
   // all ones: only bits 6, 1 and 0 stick; then unimplemented bits only (bc) clears them
   task automatic t_bits();
      wr(PIE_ADDR_ENABLE, 32'hffff_ffff);
      rd(PIE_ADDR_ENABLE);
      chk("enable all ones", rd_d, 32'h0000_0043);
      wr(PIE_ADDR_ENABLE, 32'h0000_00bc);
      rd(PIE_ADDR_ENABLE);
      chk("enable unimpl only", rd_d, 32'h0000_0000);
      chk("enable read resp", {30'h0, rsp}, 32'h0000_0000);
      strb = 4'he;
      wr(PIE_ADDR_ENABLE, 32'h0000_0043);
      strb = 4'hf;
      rd(PIE_ADDR_ENABLE);
      chk("enable low strobe", rd_d, 32'h0000_0000);
      $display("test bits done");
   endtask
   // every enable pattern with pending 111 and global off, then pending 110 and global on
   task automatic t_gate();
      logic [2:0] e, p, x;
      for (int i = 0; i < 16; i++) begin
         e = i[2:0];
         p = i[3] ? 3'b110 : 3'b111;
         x = e & p;
         wr(PIE_ADDR_ENABLE, {25'h0, e[2], 4'h0, e[1:0]});
         wr(PIE_ADDR_CTRL, {31'h0, i[3]});
         pend <= p;
         repeat (3) @(posedge clk);
         chk("request", {29'h0, req}, {29'h0, x});
         chk("periph irq", {31'h0, irq}, {31'h0, i[3] & (|x)});
         rd(PIE_ADDR_STATUS);
         chk("status", rd_d, {26'h0, x, p});
         rd(PIE_ADDR_CTRL);
         chk("global enable", rd_d, {31'h0, i[3]});
      end
      pend <= 3'b000;
      $display("test gate done");
   endtask
   // unmapped offset answers with an error and reads zero
   task automatic t_unmapped();
      wr(4'hc, 32'h0000_0043);
      chk("unmapped write resp", {30'h0, rsp}, 32'h0000_0002);
      rd(4'hc);
      chk("unmapped read resp", {30'h0, rsp}, 32'h0000_0002);
      chk("unmapped read data", rd_d, 32'h0000_0000);
      $display("test unmapped done");
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
      rready = 0; awaddr = 0; araddr = 0; wstrb = 0; wdata = 0;
      pend = 3'b000;
      repeat (3) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      t_reset();
      t_bits();
      t_gate();
      t_unmapped();
      end_sim();
   end
endmodule
